// [rtl/scem_pkg.sv]
// Package: constants, register map and types of the link error monitor
package scem_pkg;
   // Timing
   localparam int CLK_NS = 5;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam int US_PER_MS = 1000;
   localparam int OUT_LAG_MS = 2;
   localparam int OUT_LAG_US = OUT_LAG_MS * US_PER_MS;
   localparam int CFG_PROC_MS = 200;
   localparam int PROC_CYCLES = 16;
   localparam int BLINK_MS = 250;
   // Limits and reset values
   localparam logic [13:0] TIMEOUT_MAX = 14'd10000;
   localparam logic [3:0] ERRLIM_MIN = 4'h1;
   localparam logic [3:0] ERRLIM_MAX = 4'ha;
   localparam logic [13:0] TIMEOUT_RST = 14'h0;
   localparam logic [3:0] ERRLIM_RST = 4'h3;
   localparam logic [15:0] TXWAIT_RST = 16'h0;
   localparam logic [15:0] SILENT_RST = 16'h0;
   localparam int REC_DEPTH = 8;
   // Error codes
   localparam logic [7:0] CODE_SWITCH = 8'h83;
   localparam logic [7:0] CODE_TXERR = 8'h84;
   localparam logic [7:0] CODE_TIMEOUT = 8'h85;
   localparam logic [7:0] CODE_UNDEF = 8'h88;
   localparam logic [7:0] CODE_UIBUSY = 8'h89;
   localparam logic [7:0] CODE_NVBUSY = 8'h8a;
   localparam logic [7:0] CODE_RANGE = 8'h8c;
   localparam logic [7:0] CODE_DISABLED = 8'h8d;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_EXEC = 8'h04;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIMEOUT = 8'h04;
   localparam logic [7:0] OFS_ERRLIM = 8'h08;
   localparam logic [7:0] OFS_TXWAIT = 8'h0c;
   localparam logic [7:0] OFS_SILENT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_RECIDX = 8'h18;
   localparam logic [7:0] OFS_RECORD = 8'h1c;
   // Field positions
   localparam int CTRL_ALMCLR_BIT = 0;
   localparam int CTRL_RECCLR_BIT = 1;
   localparam int CTRL_STOP_LSB = 2;
   localparam int ST_ALARM_BIT = 8;
   localparam int ST_WARN_BIT = 9;
   localparam int ST_CONSEC_LSB = 10;
   localparam int ST_CFGBUSY_BIT = 14;
   localparam int REC_COUNT_LSB = 8;

   typedef enum logic [1:0] {
      CAUSE_RANGE, CAUSE_UIBUSY, CAUSE_NVBUSY, CAUSE_DISABLED
   } scem_cause_t;

   typedef enum logic [2:0] {
      QK_OTHER, QK_START, QK_STOP, QK_REMOTE, QK_CONFIG
   } scem_query_t;
endpackage

// [rtl/scem_us_tick.sv]
// Divider giving a one-cycle microsecond enable
`timescale 1ns/1ps
module scem_us_tick
   import scem_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   output logic usTick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } scem_div_t;

   scem_div_t s;
   scem_div_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == 8'(US_CYCLES - 1))
      begin
         next_s.cnt = 8'h0;
         next_s.tick = 1'b1;
      end
      else
         next_s.cnt = s.cnt + 8'h1;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign usTick = s.tick;
endmodule

// [rtl/scem_err_record.sv]
// Volatile ring of logged communication error codes
`timescale 1ns/1ps
module scem_err_record
   import scem_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic logWe,
   input wire logic [7:0] logCode,
   input wire logic logClr,
   input wire logic [2:0] rdIdx,
   output logic [7:0] rdCode,
   output logic [3:0] count
);
   typedef struct packed {
      logic [REC_DEPTH-1:0][7:0] mem;
      logic [2:0] wp;
      logic [3:0] cnt;
   } scem_rec_t;

   scem_rec_t s;
   scem_rec_t next_s;

   // Clear and log in one cycle: the new entry survives
   always_comb
   begin
      next_s = s;
      if (logClr)
      begin
         next_s.cnt = 4'h0;
         next_s.wp = 3'h0;
      end
      if (logWe)
      begin
         next_s.mem[next_s.wp] = logCode;
         next_s.wp = next_s.wp + 3'h1;
         if (next_s.cnt != 4'(REC_DEPTH))
            next_s.cnt = next_s.cnt + 4'h1;
      end
   end

   // Cleared by reset and by logClr; no nonvolatile copy
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign rdCode = s.mem[rdIdx];
   assign count = s.cnt;
endmodule

// [rtl/scem_monitor.sv]
// Top: link error monitor with alarm, warning and response timing
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module scem_monitor
   import scem_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] rateSwitch,
   input wire logic rxFrameOk,
   input wire logic rxTxError,
   input wire logic excValid,
   input wire logic [7:0] excCode,
   input wire scem_cause_t excCause,
   input wire logic queryValid,
   input wire scem_query_t queryKind,
   output logic fault_ok_output,
   output logic caution_output,
   output logic motorStop,
   output logic alarmBlink,
   output logic [1:0] stopDecel,
   output logic respSend,
   output logic outUpdate,
   output logic cfgBusy,
   output logic cfgDone
);
   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [3:0] sw1;
      logic [3:0] sw2;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [13:0] timeoutMs;
      logic [3:0] errLim;
      logic [15:0] tx_wait_time;
      logic [15:0] silentUs;
      logic [1:0] stopAction;
      logic [2:0] recIdx;
      logic [3:0] consec;
      logic warn;
      logic alarm;
      logic [7:0] alarmCode;
      logic [9:0] usInMs;
      logic [13:0] idleMs;
      logic respBusy;
      logic [16:0] respUs;
      logic [7:0] procCnt;
      logic respSend;
      logic outPend;
      logic [16:0] outUs;
      logic outUpdate;
      logic cfgBusy;
      logic [9:0] cfgMs;
      logic cfgDone;
      logic stopReq;
      logic [1:0] stopDecel;
      logic blink;
      logic [7:0] blinkMs;
      logic recWe;
      logic [7:0] recCode;
      logic recClr;
      logic faultOk;
      logic caution;
      logic motorStop;
   } scem_state_t;

   scem_state_t s;
   scem_state_t next_s;
   logic [1:0] rstPipe;
   logic rstn;
   logic usTick;
   logic [7:0] recRdCode;
   logic [3:0] recCount;

   ////////////////////////////////////////////////////////////////////////
   // Reset release and helpers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rstPipe <= 2'b00;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstn = rstPipe[1];

   scem_us_tick u_tick (
      .core_clk(core_clk),
      .rstn(rstn),
      .usTick(usTick)
   );

   scem_err_record u_rec (
      .core_clk(core_clk),
      .rstn(rstn),
      .logWe(s.recWe),
      .logCode(s.recCode),
      .logClr(s.recClr),
      .rdIdx(s.recIdx),
      .rdCode(recRdCode),
      .count(recCount)
   );

   // Exception to error code; zero means nothing to log
   function automatic logic [7:0] mapExc(input logic [7:0] code,
                                         input scem_cause_t cause);
      logic [7:0] r;
      r = 8'h00;
      if (code == EXC_FUNC || code == EXC_ADDR)
         r = CODE_UNDEF;
      else if (code == EXC_VALUE)
         r = CODE_RANGE;
      else if (code == EXC_EXEC)
      begin
         unique case (cause)
            CAUSE_RANGE: r = CODE_RANGE;
            CAUSE_UIBUSY: r = CODE_UIBUSY;
            CAUSE_NVBUSY: r = CODE_NVBUSY;
            CAUSE_DISABLED: r = CODE_DISABLED;
         endcase
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == OFS_CTRL || a == OFS_TIMEOUT || a == OFS_ERRLIM ||
             a == OFS_TXWAIT || a == OFS_SILENT || a == OFS_STATUS ||
             a == OFS_RECIDX || a == OFS_RECORD;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state
   logic msTick;
   logic setupPh;
   logic wrAcc;
   logic swErr;
   logic consecEvt;
   logic toEvt;
   logic almEvt;
   logic [7:0] almCode;
   logic [7:0] excLog;
   logic [31:0] rdVal;
   logic [16:0] waitUs;
   logic [16:0] lagUs;

   always_comb
   begin
      next_s = s;
      next_s.respSend = 1'b0;
      next_s.outUpdate = 1'b0;
      next_s.cfgDone = 1'b0;
      next_s.recWe = 1'b0;
      next_s.recClr = 1'b0;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;

      // Switch is a pin: two flops before use
      next_s.sw1 = rateSwitch;
      next_s.sw2 = s.sw1;

      msTick = usTick && s.usInMs == 10'(US_PER_MS - 1);
      if (usTick)
         next_s.usInMs = msTick ? 10'h0 : s.usInMs + 10'h1;

      waitUs = {1'b0, s.tx_wait_time} + {1'b0, s.silentUs};
      lagUs = {1'b0, s.silentUs} + 17'(OUT_LAG_US);

      // Read mux
      unique case (paddr)
         OFS_CTRL: rdVal = 32'({s.stopAction, 2'b00});
         OFS_TIMEOUT: rdVal = 32'(s.timeoutMs);
         OFS_ERRLIM: rdVal = 32'(s.errLim);
         OFS_TXWAIT: rdVal = 32'(s.tx_wait_time);
         OFS_SILENT: rdVal = 32'(s.silentUs);
         OFS_STATUS: rdVal = 32'({s.cfgBusy, s.consec, s.warn, s.alarm,
                                  s.alarmCode});
         OFS_RECIDX: rdVal = 32'(s.recIdx);
         OFS_RECORD: rdVal = 32'({recCount, recRdCode});
         default: rdVal = 32'h0;
      endcase

      // Bus: answer prepared in setup, ready in first access cycle
      setupPh = psel && !penable;
      wrAcc = psel && penable && s.pready && pwrite && !s.pslverr;
      if (setupPh)
      begin
         next_s.pready = 1'b1;
         next_s.pslverr = !mapped(paddr);
         next_s.prdata = pwrite ? 32'h0 : rdVal;
      end
      if (wrAcc)
      begin
         unique case (paddr)
            OFS_CTRL:
            begin
               next_s.stopAction = pwdata[CTRL_STOP_LSB +: 2];
               next_s.recClr = pwdata[CTRL_RECCLR_BIT];
            end
            OFS_TIMEOUT:
               next_s.timeoutMs = pwdata > 32'(TIMEOUT_MAX) ?
                  TIMEOUT_MAX : pwdata[13:0];
            OFS_ERRLIM:
               if (pwdata < 32'(ERRLIM_MIN))
                  next_s.errLim = ERRLIM_MIN;
               else if (pwdata > 32'(ERRLIM_MAX))
                  next_s.errLim = ERRLIM_MAX;
               else
                  next_s.errLim = pwdata[3:0];
            OFS_TXWAIT: next_s.tx_wait_time = pwdata[15:0];
            OFS_SILENT: next_s.silentUs = pwdata[15:0];
            OFS_RECIDX: next_s.recIdx = pwdata[2:0];
            default: ;
         endcase
      end

      ////////////////////////////////////////////////////////////////////
      // Error classification and record
      excLog = excValid ? mapExc(excCode, excCause) : 8'h00;
      if (rxTxError)
      begin
         next_s.recWe = 1'b1;
         next_s.recCode = CODE_TXERR;
      end
      else if (excLog != 8'h00)
      begin
         next_s.recWe = 1'b1;
         next_s.recCode = excLog;
      end

      // Warning and consecutive count
      consecEvt = 1'b0;
      if (rxTxError)
      begin
         next_s.warn = 1'b1;
         if (s.consec != 4'hf)
            next_s.consec = s.consec + 4'h1;
         consecEvt = 5'(s.consec) + 5'h1 >= 5'(s.errLim);
      end
      else if (rxFrameOk)
      begin
         next_s.warn = 1'b0;
         next_s.consec = 4'h0;
      end

      // Link timeout, restarted by every good frame
      if (rxFrameOk)
         next_s.idleMs = 14'h0;
      else if (msTick && s.idleMs != 14'h3fff)
         next_s.idleMs = s.idleMs + 14'h1;
      toEvt = s.timeoutMs != 14'h0 && s.idleMs >= s.timeoutMs;

      swErr = s.sw2[3];

      // First cause wins the code when several coincide
      almEvt = swErr || consecEvt || toEvt;
      if (swErr)
         almCode = CODE_SWITCH;
      else if (consecEvt)
         almCode = CODE_TXERR;
      else
         almCode = CODE_TIMEOUT;

      // Clear and new cause together: the cause wins
      if (wrAcc && paddr == OFS_CTRL && pwdata[CTRL_ALMCLR_BIT])
      begin
         next_s.alarm = 1'b0;
         next_s.alarmCode = 8'h00;
         next_s.idleMs = 14'h0;
      end
      // Re-raised after a clear: the code is taken again
      if (almEvt && (!s.alarm || next_s.alarmCode == 8'h00))
      begin
         next_s.alarm = 1'b1;
         next_s.alarmCode = almCode;
      end
      if (next_s.alarm && !s.alarm && toEvt)
         next_s.idleMs = 14'h0;

      ////////////////////////////////////////////////////////////////////
      // Indicator: on at the alarm edge, then toggling
      if (!next_s.alarm)
      begin
         next_s.blink = 1'b0;
         next_s.blinkMs = 8'h0;
      end
      else if (!s.alarm)
      begin
         next_s.blink = 1'b1;
         next_s.blinkMs = 8'h0;
      end
      else if (msTick)
      begin
         if (s.blinkMs == 8'(BLINK_MS - 1))
         begin
            next_s.blinkMs = 8'h0;
            next_s.blink = !s.blink;
         end
         else
            next_s.blinkMs = s.blinkMs + 8'h1;
      end

      ////////////////////////////////////////////////////////////////////
      // Query handling; queries during configuration are dropped
      if (queryValid && !s.cfgBusy)
      begin
         next_s.respBusy = 1'b1;
         next_s.respUs = 17'h0;
         next_s.procCnt = 8'h0;
         unique case (queryKind)
            QK_START:
            begin
               next_s.outPend = 1'b1;
               next_s.outUs = 17'h0;
               next_s.stopReq = 1'b0;
            end
            QK_REMOTE:
            begin
               next_s.outPend = 1'b1;
               next_s.outUs = 17'h0;
            end
            QK_STOP:
            begin
               next_s.stopReq = 1'b1;
               next_s.stopDecel = s.stopAction;
            end
            QK_CONFIG:
            begin
               next_s.cfgBusy = 1'b1;
               next_s.cfgMs = 10'h0;
            end
            QK_OTHER: ;
            default: ;
         endcase
      end
      else
      begin
         // One extra tick: divider phase never shortens the wait
         if (s.respBusy && s.respUs <= waitUs)
         begin
            if (usTick)
               next_s.respUs = s.respUs + 17'h1;
         end
         else if (s.respBusy)
         begin
            if (s.procCnt == 8'(PROC_CYCLES - 1))
            begin
               next_s.respBusy = 1'b0;
               next_s.respSend = 1'b1;
            end
            else
               next_s.procCnt = s.procCnt + 8'h1;
         end

         // Output update: silent interval plus a lag under 4 ms
         if (s.outPend)
         begin
            if (s.outUs >= lagUs)
            begin
               next_s.outPend = 1'b0;
               next_s.outUpdate = 1'b1;
            end
            else if (usTick)
               next_s.outUs = s.outUs + 17'h1;
         end

         // Configuration ends well inside its bound
         if (s.cfgBusy && msTick)
         begin
            if (s.cfgMs == 10'(CFG_PROC_MS - 1))
            begin
               next_s.cfgBusy = 1'b0;
               next_s.cfgDone = 1'b1;
            end
            else
               next_s.cfgMs = s.cfgMs + 10'h1;
         end
      end

      // Fault output follows the next alarm value, motor stop the next alarm or stop request; caution follows warn
      next_s.faultOk = !next_s.alarm;
      next_s.motorStop = next_s.alarm || next_s.stopReq;
      next_s.caution = next_s.warn;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.timeoutMs <= TIMEOUT_RST;
         s.errLim <= ERRLIM_RST;
         s.tx_wait_time <= TXWAIT_RST;
         s.silentUs <= SILENT_RST;
         s.faultOk <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign fault_ok_output = s.faultOk;
   assign caution_output = s.caution;
   assign motorStop = s.motorStop;
   assign alarmBlink = s.blink;
   assign stopDecel = s.stopDecel;
   assign respSend = s.respSend;
   assign outUpdate = s.outUpdate;
   assign cfgBusy = s.cfgBusy;
   assign cfgDone = s.cfgDone;
endmodule

// [verification/scem_monitor_chk.sv]
// Checker: port-level assertions of the link error monitor
`timescale 1ns/1ps
module scem_monitor_chk
   import scem_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] rateSwitch,
   input wire logic rxFrameOk,
   input wire logic rxTxError,
   input wire logic queryValid,
   input wire scem_query_t queryKind,
   input wire logic fault_ok_output,
   input wire logic caution_output,
   input wire logic motorStop,
   input wire logic alarmBlink,
   input wire logic respSend,
   input wire logic cfgBusy
);
////////////////////////////////////////
logic clrWr;
// Clear access commits at the access edge
assign clrWr = psel && penable && pwrite && paddr == OFS_CTRL
   && pwdata[CTRL_ALMCLR_BIT];
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!resetn);
// Switch passes two sync flops first
sequence s_switch_bad;
   rateSwitch[3] [*4];
endsequence
sequence s_quiet;
   !respSend [*8];
endsequence
property p_alarm_edge;
   $fell(fault_ok_output) |-> motorStop && alarmBlink;
endproperty
a_alarm_edge: assert property (p_alarm_edge)
   else $error("alarm outputs not raised together");
property p_alarm_stop;
   !fault_ok_output |-> motorStop;
endproperty
a_alarm_stop: assert property (p_alarm_stop)
   else $error("motor runs during alarm");
property p_alarm_holds;
   !fault_ok_output && !clrWr && !$past(clrWr) |=> !fault_ok_output;
endproperty
a_alarm_holds: assert property (p_alarm_holds)
   else $error("alarm dropped without clear");
property p_warn_rise;
   rxTxError && !rxFrameOk |=> caution_output;
endproperty
a_warn_rise: assert property (p_warn_rise)
   else $error("no warning after transmission error");
property p_warn_clear;
   rxFrameOk && !rxTxError |=> !caution_output;
endproperty
a_warn_clear: assert property (p_warn_clear)
   else $error("warning kept after good frame");
property p_switch;
   s_switch_bad |=> !fault_ok_output;
endproperty
a_switch: assert property (p_switch)
   else $error("no alarm on bad rate switch");
property p_resp_gap;
   queryValid && !cfgBusy |=> s_quiet;
endproperty
a_resp_gap: assert property (p_resp_gap)
   else $error("response before processing time");
property p_cfg_busy;
   queryValid && queryKind == QK_CONFIG && !cfgBusy |=> cfgBusy;
endproperty
a_cfg_busy: assert property (p_cfg_busy)
   else $error("configuration not started");
endmodule
////////////////////////////////////////
bind scem_monitor scem_monitor_chk u_scem_monitor_chk (.core_clk, .resetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .rateSwitch, .rxFrameOk,
   .rxTxError, .queryValid, .queryKind, .fault_ok_output, .caution_output,
   .motorStop, .alarmBlink, .respSend, .cfgBusy);

// [verification/scem_master_model.sv]
// Partner: query-issuing link master, event level
`timescale 1ns/1ps
module scem_master_model
   import scem_pkg::*;
(
   input wire logic core_clk,
   input wire logic cfgBusy,
   output logic rxFrameOk,
   output logic rxTxError,
   output logic excValid,
   output logic [7:0] excCode,
   output scem_cause_t excCause,
   output logic queryValid,
   output scem_query_t queryKind
);
////////////////////////////////////////
initial
begin
   rxFrameOk = 1'b0;
   rxTxError = 1'b0;
   excValid = 1'b0;
   excCode = 8'h00;
   excCause = CAUSE_RANGE;
   queryValid = 1'b0;
   queryKind = QK_OTHER;
end
task automatic pulse_frame(input logic bad);
   @(posedge core_clk);
   rxFrameOk <= !bad;
   rxTxError <= bad;
   @(posedge core_clk);
   rxFrameOk <= 1'b0;
   rxTxError <= 1'b0;
endtask
// Released fields show inverted data, never stale
task automatic send_exc(input logic [7:0] code, input scem_cause_t cause);
   @(posedge core_clk);
   excValid <= 1'b1;
   excCode <= code;
   excCause <= cause;
   @(posedge core_clk);
   excValid <= 1'b0;
   excCode <= ~code;
   excCause <= scem_cause_t'(~cause);
endtask
task automatic send_query(input scem_query_t kind);
   while (cfgBusy !== 1'b0)
      @(posedge core_clk);
   @(posedge core_clk);
   queryValid <= 1'b1;
   queryKind <= kind;
   @(posedge core_clk);
   queryValid <= 1'b0;
   queryKind <= scem_query_t'(~kind);
endtask
endmodule

// [verification/tb_scem_monitor.sv]
// Testbench: registers, link events and response timing of the monitor
`timescale 1ns/1ps
module tb_scem_monitor;
   import scem_pkg::*;
logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
logic [7:0] paddr, excCode;
logic [31:0] pwdata, prdata, rd;
logic [3:0] rateSwitch;
logic rxFrameOk, rxTxError, excValid, queryValid;
scem_cause_t excCause;
scem_query_t queryKind;
logic fault_ok_output, caution_output, motorStop, alarmBlink, respSend;
logic outUpdate, cfgBusy, cfgDone;
logic [1:0] stopDecel;
int failures = 0, totalChecks = 0, cycles = 0, n;
logic [7:0] excTab [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04};
scem_cause_t cauTab [7] = '{CAUSE_UIBUSY, CAUSE_NVBUSY, CAUSE_RANGE,
   CAUSE_RANGE, CAUSE_UIBUSY, CAUSE_NVBUSY, CAUSE_DISABLED};
logic [7:0] logTab [8] = '{8'h88, 8'h88, 8'h8c, 8'h8c, 8'h89, 8'h8a,
   8'h8d, 8'h84};
////////////////////////////////////////
scem_monitor u_scem_monitor (.core_clk, .resetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .rateSwitch, .rxFrameOk,
   .rxTxError, .excValid, .excCode, .excCause, .queryValid, .queryKind,
   .fault_ok_output, .caution_output, .motorStop, .alarmBlink, .stopDecel,
   .respSend, .outUpdate, .cfgBusy, .cfgDone);
scem_master_model u_scem_master_model (.core_clk, .cfgBusy, .rxFrameOk,
   .rxTxError, .excValid, .excCode, .excCause, .queryValid, .queryKind);
////////////////////////////////////////
initial
begin
   core_clk = 1'b0;
   forever #2.5 core_clk = ~core_clk;
end
// Whole run needs about 6200 cycles
always @(posedge core_clk)
begin
   cycles <= cycles + 1;
   if (cycles == 20000)
   begin
      failures++;
      end_of_test;
   end
end
task automatic end_of_test;
   if (failures == 0 && totalChecks > 0)
      $display("Regression OK");
   else
      $display("Regression broken");
   $finish;
endtask
task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
   totalChecks++;
   if (got !== exp)
   begin
      failures++;
      $display("wrong value at %0t: word %h, want %h", $time, got, exp);
   end
endtask
task automatic chk1(input logic got, input logic exp);
   totalChecks++;
   if (got !== exp)
   begin
      failures++;
      $display("wrong value at %0t: flag %b, want %b", $time, got, exp);
   end
endtask
task automatic cyc(input int k);
   repeat (k) @(posedge core_clk);
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   @(posedge core_clk);
   psel <= 1'b1;
   penable <= 1'b0;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge core_clk);
   penable <= 1'b1;
   do @(posedge core_clk); while (pready !== 1'b1);
   rd = prdata;
   err = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
   apb(1'b0, a, 32'h0);
   chk32(rd, exp);
endtask
////////////////////////////////////////
initial
begin
   resetn = 1'b0;
   psel = 1'b0;
   penable = 1'b0;
   pwrite = 1'b0;
   paddr = 8'h00;
   pwdata = 32'h0;
   rateSwitch = 4'h0;
   cyc(5);
   resetn <= 1'b1;
   cyc(3);
   rdchk(OFS_ERRLIM, 32'h3);
   rdchk(OFS_TIMEOUT, 32'h0);
   apb(1'b1, OFS_ERRLIM, 32'hf);
   rdchk(OFS_ERRLIM, 32'ha);
   apb(1'b1, OFS_ERRLIM, 32'h0);
   rdchk(OFS_ERRLIM, 32'h1);
   apb(1'b1, OFS_TIMEOUT, 32'd20000);
   rdchk(OFS_TIMEOUT, 32'd10000);
   apb(1'b1, OFS_TIMEOUT, 32'h0);
   rdchk(8'h40, 32'h0);
   chk1(err, 1'b1);
   // One error warns only, good frame recovers
   apb(1'b1, OFS_ERRLIM, 32'h3);
   u_scem_master_model.pulse_frame(1'b1);
   cyc(2);
   chk1(caution_output, 1'b1);
   chk1(fault_ok_output, 1'b1);
   rdchk(OFS_STATUS, 32'h600);
   u_scem_master_model.pulse_frame(1'b0);
   cyc(2);
   chk1(caution_output, 1'b0);
   rdchk(OFS_STATUS, 32'h0);
   // Threshold boundary: two errors pass, third alarms
   u_scem_master_model.pulse_frame(1'b1);
   u_scem_master_model.pulse_frame(1'b1);
   cyc(2);
   chk1(fault_ok_output, 1'b1);
   u_scem_master_model.pulse_frame(1'b1);
   cyc(2);
   chk1(fault_ok_output, 1'b0);
   chk1(motorStop, 1'b1);
   chk1(alarmBlink, 1'b1);
   rdchk(OFS_STATUS, 32'hf84);
   u_scem_master_model.pulse_frame(1'b0);
   apb(1'b1, OFS_CTRL, 32'h1);
   cyc(2);
   chk1(fault_ok_output, 1'b1);
   // Every exception mapping, then a link error, in the record
   apb(1'b1, OFS_CTRL, 32'h2);
   for (int i = 0; i < 7; i++)
      u_scem_master_model.send_exc(excTab[i], cauTab[i]);
   u_scem_master_model.pulse_frame(1'b1);
   u_scem_master_model.pulse_frame(1'b0);
   cyc(3);
   for (int i = 0; i < 8; i++)
   begin
      apb(1'b1, OFS_RECIDX, 32'(i));
      rdchk(OFS_RECORD, {20'h0, 4'h8, logTab[i]});
   end
   // Rate switch: position 7 is legal, 8 to F are not
   for (int p = 7; p < 16; p++)
   begin
      rateSwitch <= 4'(p);
      cyc(6);
      chk1(fault_ok_output, p < 8);
      if (p == 8)
         rdchk(OFS_STATUS, 32'h183);
      rateSwitch <= 4'h0;
      cyc(4);
      apb(1'b1, OFS_CTRL, 32'h1);
      cyc(2);
      chk1(fault_ok_output, 1'b1);
   end
   // Every query kind: wait 3 us plus silent 2 us plus processing
   apb(1'b1, OFS_TXWAIT, 32'h3);
   apb(1'b1, OFS_SILENT, 32'h2);
   apb(1'b1, OFS_CTRL, 32'h8);
   for (int q = 0; q < 5; q++)
   begin
      u_scem_master_model.send_query(scem_query_t'(q));
      n = 0;
      while (respSend !== 1'b1)
      begin
         @(posedge core_clk);
         n++;
      end
      chk1(n >= 1010 && n <= 1225, 1'b1);
      chk1(motorStop, q >= 2);
      chk1(outUpdate, 1'b0);
      chk1(cfgDone, 1'b0);
   end
   chk32({30'h0, stopDecel}, 32'h2);
   chk1(motorStop, 1'b1);
   chk1(cfgBusy, 1'b1);
   end_of_test;
end
endmodule
